// ### remote_sensor_spi_command_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "sensor_cmd_map.vh"
module remote_sensor_spi_command_ctrl (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Serial link pins to and from the master
  input wire spi_sel_n,
  input wire spi_clk,
  input wire spi_din,
  output reg spi_dout,
  output reg spi_dout_oe,
  // Analog side status inputs
  input wire chan0_current_high,
  input wire chan1_current_high,
  input wire program_supply_ok,
  // Sensor data pins, split into in, out, enable
  input wire sensor_data_pin0_in,
  input wire sensor_data_pin1_in,
  output reg sensor_data_pin0_out,
  output reg sensor_data_pin1_out,
  output reg sensor_data_pin0_oe,
  output reg sensor_data_pin1_oe,
  // Supply, ground switch and modulation controls
  output reg remote_supply_pin0_en,
  output reg remote_supply_pin1_en,
  output reg sensor_ground_switch0_en,
  output reg sensor_ground_switch1_en,
  output reg remote_supply_pin0_high,
  output reg remote_supply_pin1_high,
  output reg prog_mode_flag
);

  // Two-stage synchronisers for all pins from outside the clock domain
  reg [1:0] sel_sync_reg;
  reg [1:0] clk_sync_reg;
  reg [1:0] din_sync_reg;
  reg [1:0] cur0_sync_reg;
  reg [1:0] cur1_sync_reg;
  reg [1:0] vp_sync_reg;
  reg [1:0] pin0_sync_reg;
  reg [1:0] pin1_sync_reg;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sel_sync_reg <= 2'b11;
      clk_sync_reg <= 2'b00;
      din_sync_reg <= 2'b00;
      cur0_sync_reg <= 2'b00;
      cur1_sync_reg <= 2'b00;
      vp_sync_reg <= 2'b00;
      pin0_sync_reg <= 2'b00;
      pin1_sync_reg <= 2'b00;
    end else begin
      sel_sync_reg <= {sel_sync_reg[0], spi_sel_n};
      clk_sync_reg <= {clk_sync_reg[0], spi_clk};
      din_sync_reg <= {din_sync_reg[0], spi_din};
      cur0_sync_reg <= {cur0_sync_reg[0], chan0_current_high};
      cur1_sync_reg <= {cur1_sync_reg[0], chan1_current_high};
      vp_sync_reg <= {vp_sync_reg[0], program_supply_ok};
      pin0_sync_reg <= {pin0_sync_reg[0], sensor_data_pin0_in};
      pin1_sync_reg <= {pin1_sync_reg[0], sensor_data_pin1_in};
    end
  end

  // Previous synchronised levels for edge finding
  reg sel_prev_reg;
  reg clk_prev_reg;
  wire sel_n = sel_sync_reg[1];
  wire sclk = clk_sync_reg[1];
  wire frame_start = sel_prev_reg & ~sel_n;
  wire frame_end = ~sel_prev_reg & sel_n;
  wire sclk_fall = clk_prev_reg & ~sclk & ~sel_n;
  wire sclk_rise = ~clk_prev_reg & sclk & ~sel_n;

  // Frame state
  reg [15:0] rx_shift_reg;
  reg [15:0] tx_shift_reg;
  reg [15:0] answer_reg;
  reg [4:0] bit_count_reg;
  reg count_over_reg;
  reg chan0_state_reg;
  reg chan1_state_reg;
  reg prog_req_reg;

  // Classify the finished frame; exact patterns only
  reg [15:0] reply_next;
  reg chan0_state_next;
  reg chan1_state_next;
  reg prog_req_next;
  reg frame_ok;
  always @* begin
    reply_next = `ALL_ONES_WORD;
    chan0_state_next = chan0_state_reg;
    chan1_state_next = chan1_state_reg;
    prog_req_next = prog_req_reg;
    frame_ok = (bit_count_reg == `FRAME_BITS) & ~count_over_reg;
    if (!frame_ok) begin
      reply_next = `ALL_ONES_WORD;
    end else if (rx_shift_reg[2:0] == `CODE_POWER_SWITCH &&
                 rx_shift_reg[15:7] == 9'h000) begin
      if (rx_shift_reg[`POS_CHAN0_SELECT]) begin
        chan0_state_next = rx_shift_reg[`POS_CHAN0_ON_REQUEST];
      end
      if (rx_shift_reg[`POS_CHAN1_SELECT]) begin
        chan1_state_next = rx_shift_reg[`POS_CHAN1_ON_REQUEST];
      end
      reply_next = {6'h00, chan1_state_next, chan0_state_next,
                    rx_shift_reg[7:0]};
    end else if ((rx_shift_reg & `PROG_WORD_MASK) ==
                 `PROG_WORD_BASE) begin
      prog_req_next = rx_shift_reg[`POS_PROG_MODE_FLAG];
      reply_next = rx_shift_reg;
      reply_next[`POS_PROG_STATUS] = prog_req_next & vp_sync_reg[1];
    end else if (rx_shift_reg == `NO_OP_WORD) begin
      reply_next = rx_shift_reg;
    end
  end

  // Serial engine: sample on falling, shift out on rising, lsb first
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sel_prev_reg <= 1'b1;
      clk_prev_reg <= 1'b0;
      rx_shift_reg <= 16'h0000;
      tx_shift_reg <= `RESET_ANSWER;
      answer_reg <= `RESET_ANSWER;
      bit_count_reg <= 5'h00;
      count_over_reg <= 1'b0;
      chan0_state_reg <= 1'b0;
      chan1_state_reg <= 1'b0;
      prog_req_reg <= 1'b0;
      spi_dout <= 1'b0;
      spi_dout_oe <= 1'b0;
    end else begin
      sel_prev_reg <= sel_n;
      clk_prev_reg <= sclk;
      spi_dout_oe <= ~sel_n;
      if (frame_start) begin
        // Pending answer loaded; bit 0 shows before the first clock
        tx_shift_reg <= {1'b0, answer_reg[15:1]};
        spi_dout <= answer_reg[0];
        bit_count_reg <= 5'h00;
        count_over_reg <= 1'b0;
      end else begin
        if (sclk_fall) begin
          rx_shift_reg <= {din_sync_reg[1], rx_shift_reg[15:1]};
          if (bit_count_reg == 5'h1f) begin
            count_over_reg <= 1'b1;
          end else begin
            bit_count_reg <= bit_count_reg + 5'h01;
          end
        end
        // Rising edge after the first falling one moves to next bit
        if (sclk_rise && bit_count_reg != 5'h00) begin
          spi_dout <= tx_shift_reg[0];
          tx_shift_reg <= {1'b0, tx_shift_reg[15:1]};
        end
      end
      if (frame_end) begin
        // Frame judged only when select rises, so length is known
        answer_reg <= reply_next;
        chan0_state_reg <= chan0_state_next;
        chan1_state_reg <= chan1_state_next;
        prog_req_reg <= prog_req_next;
      end
    end
  end

  // Pin and switch drivers; sensor pin role depends on mode
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      remote_supply_pin0_en <= 1'b0;
      remote_supply_pin1_en <= 1'b0;
      sensor_ground_switch0_en <= 1'b0;
      sensor_ground_switch1_en <= 1'b0;
      remote_supply_pin0_high <= 1'b0;
      remote_supply_pin1_high <= 1'b0;
      sensor_data_pin0_out <= 1'b1;
      sensor_data_pin1_out <= 1'b1;
      sensor_data_pin0_oe <= 1'b1;
      sensor_data_pin1_oe <= 1'b1;
      prog_mode_flag <= 1'b0;
    end else begin
      remote_supply_pin0_en <= chan0_state_reg;
      remote_supply_pin1_en <= chan1_state_reg;
      sensor_ground_switch0_en <= chan0_state_reg;
      sensor_ground_switch1_en <= chan1_state_reg;
      prog_mode_flag <= prog_req_reg;
      sensor_data_pin0_oe <= ~prog_req_reg;
      sensor_data_pin1_oe <= ~prog_req_reg;
      sensor_data_pin0_out <= ~cur0_sync_reg[1];
      sensor_data_pin1_out <= ~cur1_sync_reg[1];
      // Modulation blocked outside program mode; low is the default
      remote_supply_pin0_high <= prog_req_reg & pin0_sync_reg[1];
      remote_supply_pin1_high <= prog_req_reg & pin1_sync_reg[1];
    end
  end

endmodule
`default_nettype wire

// ### remote_sensor_spi_command_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module remote_sensor_spi_command_ctrl_props (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Pins under watch
  input wire spi_sel_n,
  input wire spi_dout_oe,
  input wire sensor_data_pin0_oe,
  input wire sensor_data_pin1_oe,
  input wire remote_supply_pin0_en,
  input wire remote_supply_pin1_en,
  input wire sensor_ground_switch0_en,
  input wire sensor_ground_switch1_en,
  input wire remote_supply_pin0_high,
  input wire prog_mode_flag
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // Long deselect, so the synced output enable has settled
  sequence sel_idle;
    spi_sel_n [*8];
  endsequence
  // Frame opened and held past the select sync delay
  sequence frame_start;
    $fell(spi_sel_n) ##1 !spi_sel_n [*5];
  endsequence
  a_dout_released: assert property (sel_idle |-> !spi_dout_oe)
    else $error("output driven while deselected");
  a_dout_driven: assert property (frame_start |-> spi_dout_oe)
    else $error("output not driven in frame");
  a_ground_follow: assert property (
    sensor_ground_switch0_en == remote_supply_pin0_en &&
    sensor_ground_switch1_en == remote_supply_pin1_en)
    else $error("ground switch differs from supply");
  a_pin_output: assert property (
    !prog_mode_flag [*3] |-> sensor_data_pin0_oe && sensor_data_pin1_oe)
    else $error("data pin not output in normal mode");
  a_pin_input: assert property (
    prog_mode_flag [*3] |-> !sensor_data_pin0_oe && !sensor_data_pin1_oe)
    else $error("data pin driven in program mode");
  a_mod_blocked: assert property (
    !prog_mode_flag [*3] |-> !remote_supply_pin0_high)
    else $error("modulation outside program mode");
  a_state_frame: assert property (
    $changed(remote_supply_pin0_en) || $changed(prog_mode_flag)
    |-> spi_sel_n && $past(spi_sel_n, 3))
    else $error("state changed inside a frame");
  a_reset_off: assert property ($fell(reset) |-> !prog_mode_flag &&
    !remote_supply_pin0_en && !remote_supply_pin1_en)
    else $error("state not cleared by reset");
endmodule
`default_nettype wire

// ### remote_sensor_spi_command_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module remote_sensor_spi_command_ctrl_tb_top;
  // Stimulus and observed pins
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic chan0_current_high = 1'b0;
  logic chan1_current_high = 1'b0;
  logic program_supply_ok = 1'b0;
  logic sensor_data_pin0_in = 1'b0;
  logic sensor_data_pin1_in = 1'b0;
  wire spi_sel_n, spi_clk, spi_din, spi_dout, spi_dout_oe, prog_mode_flag;
  wire sensor_data_pin0_out, sensor_data_pin1_out;
  wire sensor_data_pin0_oe, sensor_data_pin1_oe;
  wire remote_supply_pin0_en, remote_supply_pin1_en;
  wire sensor_ground_switch0_en, sensor_ground_switch1_en;
  wire remote_supply_pin0_high, remote_supply_pin1_high;
  int error_cnt = 0;
  int cmp_count = 0;
  remote_sensor_spi_command_ctrl u_remote_sensor_spi_command_ctrl (
    .core_clk(core_clk),
    .reset(reset),
    .spi_sel_n(spi_sel_n),
    .spi_clk(spi_clk),
    .spi_din(spi_din),
    .spi_dout(spi_dout),
    .spi_dout_oe(spi_dout_oe),
    .chan0_current_high(chan0_current_high),
    .chan1_current_high(chan1_current_high),
    .program_supply_ok(program_supply_ok),
    .sensor_data_pin0_in(sensor_data_pin0_in),
    .sensor_data_pin1_in(sensor_data_pin1_in),
    .sensor_data_pin0_out(sensor_data_pin0_out),
    .sensor_data_pin1_out(sensor_data_pin1_out),
    .sensor_data_pin0_oe(sensor_data_pin0_oe),
    .sensor_data_pin1_oe(sensor_data_pin1_oe),
    .remote_supply_pin0_en(remote_supply_pin0_en),
    .remote_supply_pin1_en(remote_supply_pin1_en),
    .sensor_ground_switch0_en(sensor_ground_switch0_en),
    .sensor_ground_switch1_en(sensor_ground_switch1_en),
    .remote_supply_pin0_high(remote_supply_pin0_high),
    .remote_supply_pin1_high(remote_supply_pin1_high),
    .prog_mode_flag(prog_mode_flag)
  );
  spi_master_model u_spi_master_model (
    .spi_sel_n(spi_sel_n),
    .spi_clk(spi_clk),
    .spi_din(spi_din),
    .spi_dout(spi_dout),
    .spi_dout_oe(spi_dout_oe)
  );
  // Core clock
  initial forever #25 core_clk = ~core_clk;
  // Verdict, reached from the main sequence and the watchdog
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Answers lag one frame, so each frame judges the previous command
  task automatic run(input logic [15:0] tx, input int n, input logic [15:0] exp);
    logic [15:0] rx;
    u_spi_master_model.frame(tx, n, rx);
    cmp(rx, exp);
  endtask
  task automatic t_switch;
    cmp(remote_supply_pin0_en, 1'b0);
    run(16'h001c, 16, 16'h9101);
    run(16'h0064, 16, 16'h011c);
    cmp(sensor_ground_switch0_en, 1'b1);
    run(16'h000c, 16, 16'h0364);
    run(16'h9101, 16, 16'h020c);
    cmp(remote_supply_pin0_en, 1'b0);
    cmp(remote_supply_pin1_en, 1'b1);
  endtask
  // Bad length, diag codes and stray high bits are refused
  task automatic t_refuse;
    run(16'h001c, 17, 16'h9101);
    cmp(remote_supply_pin0_en, 1'b0);
    run(16'h0002, 16, 16'hffff);
    run(16'h0006, 16, 16'hffff);
    run(16'h801c, 16, 16'hffff);
    run(16'h9101, 16, 16'hffff);
    cmp(remote_supply_pin0_en, 1'b0);
  endtask
  task automatic t_prog;
    @(posedge core_clk);
    program_supply_ok <= 1'b1;
    chan0_current_high <= 1'b1;
    run(16'h184d, 16, 16'h9101);
    cmp(prog_mode_flag, 1'b1);
    cmp(sensor_data_pin0_oe, 1'b0);
    cmp(sensor_data_pin1_oe, 1'b0);
    cmp(remote_supply_pin0_high, 1'b0);
    @(posedge core_clk);
    sensor_data_pin0_in <= 1'b1;
    sensor_data_pin1_in <= 1'b1;
    program_supply_ok <= 1'b0;
    repeat (8) @(posedge core_clk);
    cmp(remote_supply_pin0_high, 1'b1);
    cmp(remote_supply_pin1_high, 1'b1);
    run(16'h1845, 16, 16'h194d);
    cmp(sensor_data_pin0_out, 1'b0);
    cmp(sensor_data_pin1_out, 1'b1);
    cmp(prog_mode_flag, 1'b0);
    cmp(remote_supply_pin0_high, 1'b0);
    cmp(remote_supply_pin1_high, 1'b0);
    run(16'h184d, 16, 16'h1845);
    run(16'h1845, 16, 16'h184d);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_switch;
    t_refuse;
    t_prog;
    report_and_stop;
  end
  // Watchdog well beyond the expected run of about 114 us
  initial begin
    #1000000;
    error_cnt++;
    report_and_stop;
  end
endmodule
bind remote_sensor_spi_command_ctrl remote_sensor_spi_command_ctrl_props u_props (
  .core_clk(core_clk),
  .reset(reset),
  .spi_sel_n(spi_sel_n),
  .spi_dout_oe(spi_dout_oe),
  .sensor_data_pin0_oe(sensor_data_pin0_oe),
  .sensor_data_pin1_oe(sensor_data_pin1_oe),
  .remote_supply_pin0_en(remote_supply_pin0_en),
  .remote_supply_pin1_en(remote_supply_pin1_en),
  .sensor_ground_switch0_en(sensor_ground_switch0_en),
  .sensor_ground_switch1_en(sensor_ground_switch1_en),
  .remote_supply_pin0_high(remote_supply_pin0_high),
  .prog_mode_flag(prog_mode_flag)
);
`default_nettype wire

// ### sensor_cmd_map.vh
// Contract
// - Device is always slave on a 16-bit serial link; master makes select and clock.
// - Select is active low; a frame begins on its falling edge.
// - Clock idles low; sample input on falling edge, shift output on rising edge.
// - Serial output is released (not driven) while select is high.
// - Count clock pulses in every select-low period to check exact frame length.
// - Answer to the first command after start-up equals the no-op answer.
// - Bits 0 to 2 form the command code; other bits are data.
// - Command and answer travel least significant bit first up to bit 15.
// - Each answer is sent in the frame after its command.
// - Act only when the whole word exactly matches a defined command pattern.
// - Answer echoes the command word except bits carrying status.
// - An undefined command is answered with all ones.
// - Codes: 100 switch, 010 diag on, 110 diag off, 101 program, 001 no-op; the code answers both diag codes with all ones.
// - Bits 3 and 5 select channels; bits 4 and 6 request on or off.
// - Switch answer echoes low byte, channel states in bits 8 and 9, zeros above.
// - Program bit enables or disables program mode; other commands are unaffected.
// - Program answer reports mode in bit 8, one only with program supply good.
// - Ground switch of a channel follows that channel's supply on state.
// - Normal mode: data pin is output, low on high current, high on quiescent.
// - Program mode: data pin is input; high selects high voltage, low default.
// - Voltage modulation toward remote unit allowed only in program mode.
// - No-op answer echoes both bytes unchanged.
`ifndef SENSOR_CMD_MAP_VH
`define SENSOR_CMD_MAP_VH
`define FRAME_BITS 16
`define CODE_POWER_SWITCH 3'h4
`define CODE_DIAG_WHILE_ON 3'h2
`define CODE_DIAG_WHILE_OFF 3'h6
`define CODE_PROG 3'h5
`define CODE_NO_OP 3'h1
`define POS_CHAN0_SELECT 3
`define POS_CHAN0_ON_REQUEST 4
`define POS_CHAN1_SELECT 5
`define POS_CHAN1_ON_REQUEST 6
`define POS_PROG_MODE_FLAG 3
`define POS_CHAN0_STATE 8
`define POS_CHAN1_STATE 9
`define POS_PROG_STATUS 8
`define NO_OP_WORD 16'h9101
`define PROG_WORD_BASE 16'h1845
`define PROG_WORD_MASK 16'hfff7
`define ALL_ONES_WORD 16'hffff
`define RESET_ANSWER 16'h9101
`endif

// ### spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  // Serial pins to and from the device
  output logic spi_sel_n,
  output logic spi_clk,
  output logic spi_din,
  input wire spi_dout,
  input wire spi_dout_oe
);
  // Deselected and clock low when idle
  initial begin
    spi_sel_n = 1'b1;
    spi_clk = 1'b0;
    spi_din = 1'b1;
  end
  // One frame of n clocks; output sampled just before each fall, x if
  // released. Sampling before the rise would read the previous bit,
  // since the slave moves to the next bit on the rising edge.
  task automatic frame(input logic [15:0] tx, input int n,
                       output logic [15:0] rx);
    rx = 16'hxxxx;
    #13 spi_sel_n = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      spi_din = tx[i[3:0]];
      spi_clk = 1'b1;
      #200;
      if (i < 16) rx[i] = spi_dout_oe ? spi_dout : 1'bx;
      spi_clk = 1'b0;
      #200;
    end
    spi_sel_n = 1'b1;
    spi_din = ~spi_din;
    #2000;
  endtask
endmodule
`default_nettype wire
